// file: core/ebc_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts of the byte access block
// Assumes: 125 MHz pclk; programming timed on a derived RC-rate tick
// Notes: Included by bare name from both ends
`ifndef EBC_CFG_SVH
`define EBC_CFG_SVH

// I/O register addresses seen by the core (data byte address chosen to fill the gap)
`define EBC_IO_CTRL 6'h1F
`define EBC_IO_DATA 6'h20
`define EBC_IO_PTR_LO 6'h21
`define EBC_IO_PTR_HI 6'h22

// Control register bit positions
`define EBC_B_READ 0
`define EBC_B_STROBE 1
`define EBC_B_ARM 2
`define EBC_B_IRQEN 3
`define EBC_B_MODE_LO 4
`define EBC_B_MODE_HI 5
`define EBC_MODE_RST 2'h0

// Timing
`define EBC_CLK_MHZ 125
`define EBC_T_ATOMIC_US 3400
`define EBC_T_HALF_US 1800
`define EBC_T_TYP_US 3300
`define EBC_RC_ATOMIC 26368
`define EBC_RC_HALF (`EBC_RC_ATOMIC * `EBC_T_HALF_US / `EBC_T_ATOMIC_US)
`define EBC_RC_DIV (`EBC_CLK_MHZ * `EBC_T_TYP_US / `EBC_RC_ATOMIC)
`define EBC_ARM_CYC 4
`define EBC_WR_STALL 2
`define EBC_RD_STALL 4

// Controller APB register offsets
`define EBC_A_CMD 8'h00
`define EBC_A_ADDR 8'h04
`define EBC_A_WDATA 8'h08
`define EBC_A_STATUS 8'h0C
`define EBC_A_CFG 8'h10

`endif

// file: core/ebc_device.sv
// Purpose: Byte access device: pointer, data and control registers over a nonvolatile array
// Assumes: Core accesses come on pclk; por_n is the power-on reset, presetn the system reset
// Notes: Programming state sits on por_n so a system reset does not cut a write short
`include "ebc_cfg.svh"

module ebc_device #(
  parameter int RC_DIV = `EBC_RC_DIV,
  parameter int RC_ATOMIC = `EBC_RC_ATOMIC,
  parameter int RC_HALF = `EBC_RC_HALF,
  parameter int PTR_W = 9
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  ebc_if.dev io,
  output logic prog_busy
);
  localparam int DEPTH = 1 << PTR_W;

  logic [7:0] mem [DEPTH];
  logic [PTR_W-1:0] ptr_r;
  logic [7:0] data_r;
  logic [7:0] prog_data_r;
  ebc_pkg::ebc_mode_e mode_r;
  logic irq_en_r;
  logic arm_r;
  logic [1:0] arm_cnt_r;
  logic strobe_r;
  logic [4:0] div_r;
  logic [15:0] rc_cnt_r;
  logic [2:0] stall_r;
  logic [7:0] rdata_r;
  logic ctrl_wr;
  logic strike;
  logic start;
  logic read_go;
  logic rc_tick;
  logic done;
  logic [15:0] rc_limit;

  // Decode of core writes to the control register
  assign ctrl_wr = io.io_wr && (io.io_addr == `EBC_IO_CTRL);
  assign strike = ctrl_wr && io.io_wdata[`EBC_B_STROBE] && !strobe_r;
  // A strike only counts while armed, no flash store runs, and mode is legal
  assign start = strike && arm_r && !io.flash_selfprog_active
    && (mode_r != ebc_pkg::EBC_MODE_RSVD);
  assign read_go = ctrl_wr && io.io_wdata[`EBC_B_READ] && !strobe_r;
  assign rc_tick = (div_r == 5'(RC_DIV - 1));
  // Duration depends on the action latched in the mode field
  assign rc_limit = (mode_r == ebc_pkg::EBC_MODE_ATOMIC) ? 16'(RC_ATOMIC) : 16'(RC_HALF);
  assign done = strobe_r && rc_tick && (rc_cnt_r == rc_limit - 16'h0001);

  // Mode field: frozen while programming, cleared by system reset only when idle
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      mode_r <= ebc_pkg::ebc_mode_e'(`EBC_MODE_RST);
    end else if (!presetn) begin
      if (!strobe_r) begin
        mode_r <= ebc_pkg::ebc_mode_e'(`EBC_MODE_RST);
      end
    end else if (ctrl_wr && !strobe_r) begin
      mode_r <= ebc_pkg::ebc_mode_e'(io.io_wdata[`EBC_B_MODE_HI:`EBC_B_MODE_LO]);
    end
  end

  // Ready interrupt enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= 1'b0;
    end else if (ctrl_wr) begin
      irq_en_r <= io.io_wdata[`EBC_B_IRQEN];
    end
  end

  // Arm bit lives four cycles, or until a strike consumes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_r <= 1'b0;
      arm_cnt_r <= 2'h0;
    end else if (ctrl_wr && io.io_wdata[`EBC_B_ARM] && !io.io_wdata[`EBC_B_STROBE]) begin
      arm_r <= 1'b1;
      arm_cnt_r <= 2'h0;
    end else if (start || (arm_r && arm_cnt_r == 2'(`EBC_ARM_CYC - 1))) begin
      arm_r <= 1'b0;
      arm_cnt_r <= 2'h0;
    end else if (arm_r) begin
      arm_cnt_r <= arm_cnt_r + 2'h1;
    end
  end

  // RC-rate tick from pclk; kept on por_n so timing survives system reset
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      div_r <= 5'h00;
    end else if (rc_tick || start) begin
      div_r <= 5'h00;
    end else begin
      div_r <= div_r + 5'h01;
    end
  end

  // Programming engine: strobe stays set until the RC count runs out
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      strobe_r <= 1'b0;
      rc_cnt_r <= 16'h0000;
      prog_data_r <= 8'h00;
    end else if (start) begin
      strobe_r <= 1'b1;
      rc_cnt_r <= 16'h0000;
      prog_data_r <= data_r;
    end else if (done) begin
      strobe_r <= 1'b0;
    end else if (strobe_r && rc_tick) begin
      rc_cnt_r <= rc_cnt_r + 16'h0001;
    end
  end

  // Array commit at the end of the timed operation
  always_ff @(posedge pclk) begin
    if (done) begin
      unique case (mode_r)
        ebc_pkg::EBC_MODE_ATOMIC: mem[ptr_r] <= prog_data_r;
        ebc_pkg::EBC_MODE_ERASE: mem[ptr_r] <= 8'hFF;
        ebc_pkg::EBC_MODE_WRITE: mem[ptr_r] <= mem[ptr_r] & prog_data_r;
        ebc_pkg::EBC_MODE_RSVD: mem[ptr_r] <= mem[ptr_r];
      endcase
    end
  end

  // Byte pointer has no reset value; software must load it first
  always_ff @(posedge pclk) begin
    if (io.io_wr && !strobe_r) begin
      if (io.io_addr == `EBC_IO_PTR_LO) begin
        ptr_r[7:0] <= io.io_wdata;
      end else if (io.io_addr == `EBC_IO_PTR_HI) begin
        ptr_r[PTR_W-1:8] <= io.io_wdata[PTR_W-9:0];
      end
    end
  end

  // Data register: software writes, or the byte fetched by a read strobe
  always_ff @(posedge pclk) begin
    if (read_go) begin
      data_r <= mem[ptr_r];
    end else if (io.io_wr && io.io_addr == `EBC_IO_DATA) begin
      data_r <= io.io_wdata;
    end
  end

  // Stall counter holds the core after a strike or a read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_r <= 3'h0;
    end else if (read_go) begin
      stall_r <= 3'(`EBC_RD_STALL);
    end else if (start) begin
      stall_r <= 3'(`EBC_WR_STALL);
    end else if (stall_r != 3'h0) begin
      stall_r <= stall_r - 3'h1;
    end
  end

  // Read mux, registered; read strobe never reads back as set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= 8'h00;
    end else if (io.io_rd) begin
      unique case (io.io_addr)
        `EBC_IO_CTRL: rdata_r <= {2'b00, mode_r, irq_en_r, arm_r, strobe_r, 1'b0};
        `EBC_IO_DATA: rdata_r <= data_r;
        `EBC_IO_PTR_LO: rdata_r <= ptr_r[7:0];
        `EBC_IO_PTR_HI: rdata_r <= 8'(ptr_r[PTR_W-1:8]);
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  assign io.io_rdata = rdata_r;
  assign io.cpu_stall = (stall_r != 3'h0);
  // Level interrupt; masked during a write and during flash self-programming
  assign io.ready_irq = irq_en_r && io.global_irq_en && !strobe_r
    && !io.flash_selfprog_active;
  assign prog_busy = strobe_r;
endmodule // ebc_device

// file: core/ebc_host.sv
// Purpose: Core-side controller that drives the byte access device from APB commands
// Assumes: Zero-wait APB slave on pclk; device on the same clock
// Notes: Byte writes run the full poll, load, arm and strike sequence in hardware; byte reads poll, load and read-strobe
`include "ebc_cfg.svh"

module ebc_host #(
  parameter bit SMALL_MEM = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ebc_if.core io
);
  ebc_pkg::ebc_state_e state_r;
  ebc_pkg::ebc_op_e op_r;
  logic [1:0] mode_r;
  logic irq_en_r;
  logic [8:0] addr_r;
  logic [7:0] wdata_r;
  logic [7:0] result_r;
  logic gie_r;
  logic flash_r;
  logic [31:0] prdata_r;
  logic [5:0] io_addr_r;
  logic io_wr_r;
  logic io_rd_r;
  logic [7:0] io_wdata_r;
  logic acc_wr;
  logic go;
  logic mapped;
  logic [7:0] ctrl_base;

  assign acc_wr = psel && penable && pwrite;
  assign go = acc_wr && (paddr == `EBC_A_CMD) && (state_r == ebc_pkg::EBC_S_IDLE);
  assign mapped = (paddr == `EBC_A_CMD) || (paddr == `EBC_A_ADDR) || (paddr == `EBC_A_WDATA)
    || (paddr == `EBC_A_STATUS) || (paddr == `EBC_A_CFG);
  assign ctrl_base = {2'b00, mode_r, irq_en_r, 3'b000};

  // Software-written setup registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r <= ebc_pkg::EBC_OP_RAW_WR;
      mode_r <= 2'h0;
      irq_en_r <= 1'b0;
      addr_r <= 9'h000;
      wdata_r <= 8'h00;
      gie_r <= 1'b0;
      flash_r <= 1'b0;
    end else if (go) begin
      op_r <= ebc_pkg::ebc_op_e'(pwdata[1:0]);
      mode_r <= pwdata[3:2];
      irq_en_r <= pwdata[4];
    end else if (acc_wr && paddr == `EBC_A_ADDR) begin
      addr_r <= pwdata[8:0];
    end else if (acc_wr && paddr == `EBC_A_WDATA) begin
      wdata_r <= pwdata[7:0];
    end else if (acc_wr && paddr == `EBC_A_CFG) begin
      gie_r <= pwdata[0];
      flash_r <= pwdata[1];
    end
  end

  // APB read data captured in the setup cycle, shown in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      unique case (paddr)
        `EBC_A_CMD: prdata_r <= {27'h0, irq_en_r, mode_r, op_r};
        `EBC_A_ADDR: prdata_r <= {23'h0, addr_r};
        `EBC_A_WDATA: prdata_r <= {24'h0, wdata_r};
        `EBC_A_STATUS: prdata_r <= {16'h0, result_r, 6'h0, io.ready_irq,
          state_r != ebc_pkg::EBC_S_IDLE};
        `EBC_A_CFG: prdata_r <= {30'h0, flash_r, gie_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Sequencer: one I/O access per step, idle while the device stalls the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ebc_pkg::EBC_S_IDLE;
      io_addr_r <= 6'h00;
      io_wr_r <= 1'b0;
      io_rd_r <= 1'b0;
      io_wdata_r <= 8'h00;
      result_r <= 8'h00;
    end else begin
      io_wr_r <= 1'b0;
      io_rd_r <= 1'b0;
      unique case (state_r)
        ebc_pkg::EBC_S_IDLE: begin
          if (go) begin
            io_addr_r <= 6'(pwdata[13:8]);
            io_wdata_r <= pwdata[23:16];
            unique case (ebc_pkg::ebc_op_e'(pwdata[1:0]))
              ebc_pkg::EBC_OP_RAW_WR: begin
                io_wr_r <= 1'b1;
                state_r <= ebc_pkg::EBC_S_SETTLE;
              end
              ebc_pkg::EBC_OP_RAW_RD: begin
                io_rd_r <= 1'b1;
                state_r <= ebc_pkg::EBC_S_RDGET;
              end
              default: state_r <= ebc_pkg::EBC_S_POLL;
            endcase
          end
        end
        ebc_pkg::EBC_S_POLL: begin
          if (!io.cpu_stall) begin
            io_rd_r <= 1'b1;
            io_addr_r <= `EBC_IO_CTRL;
            state_r <= ebc_pkg::EBC_S_POLLCHK;
          end
        end
        ebc_pkg::EBC_S_POLLCHK: begin
          // Read data lands one cycle after the read pulse; hold while the pulse stands
          // Wait for strobe clear, and for flash stores before a write
          if (io_rd_r) begin
            state_r <= ebc_pkg::EBC_S_POLLCHK;
          end else if (io.io_rdata[`EBC_B_STROBE]
              || (op_r == ebc_pkg::EBC_OP_BYTE_WR && flash_r)) begin
            state_r <= ebc_pkg::EBC_S_POLL;
          end else begin
            state_r <= ebc_pkg::EBC_S_PTRH;
          end
        end
        ebc_pkg::EBC_S_PTRH: begin
          io_wr_r <= 1'b1;
          io_addr_r <= `EBC_IO_PTR_HI;
          io_wdata_r <= {7'h00, addr_r[8] && !SMALL_MEM};
          state_r <= ebc_pkg::EBC_S_PTRL;
        end
        ebc_pkg::EBC_S_PTRL: begin
          io_wr_r <= 1'b1;
          io_addr_r <= `EBC_IO_PTR_LO;
          io_wdata_r <= addr_r[7:0];
          state_r <= (op_r == ebc_pkg::EBC_OP_BYTE_WR) ? ebc_pkg::EBC_S_DATA
            : ebc_pkg::EBC_S_RSTRB;
        end
        ebc_pkg::EBC_S_DATA: begin
          io_wr_r <= 1'b1;
          io_addr_r <= `EBC_IO_DATA;
          io_wdata_r <= wdata_r;
          state_r <= ebc_pkg::EBC_S_ARM;
        end
        ebc_pkg::EBC_S_ARM: begin
          io_wr_r <= 1'b1;
          io_addr_r <= `EBC_IO_CTRL;
          io_wdata_r <= ctrl_base | 8'h04;
          state_r <= ebc_pkg::EBC_S_STRIKE;
        end
        ebc_pkg::EBC_S_STRIKE: begin
          // Strike on the very next cycle, well inside the arm window
          io_wr_r <= 1'b1;
          io_addr_r <= `EBC_IO_CTRL;
          io_wdata_r <= ctrl_base | 8'h06;
          state_r <= ebc_pkg::EBC_S_SETTLE;
        end
        ebc_pkg::EBC_S_RSTRB: begin
          io_wr_r <= 1'b1;
          io_addr_r <= `EBC_IO_CTRL;
          io_wdata_r <= ctrl_base | 8'h01;
          state_r <= ebc_pkg::EBC_S_SETTLE;
        end
        // One quiet cycle: the stall only shows one cycle after the access
        ebc_pkg::EBC_S_SETTLE: state_r <= ebc_pkg::EBC_S_WAITS;
        ebc_pkg::EBC_S_WAITS: begin
          if (!io.cpu_stall) begin
            if (op_r == ebc_pkg::EBC_OP_BYTE_RD) begin
              io_rd_r <= 1'b1;
              io_addr_r <= `EBC_IO_DATA;
              state_r <= ebc_pkg::EBC_S_RDGET;
            end else begin
              state_r <= ebc_pkg::EBC_S_IDLE;
            end
          end
        end
        ebc_pkg::EBC_S_RDGET: begin
          // Taking the byte while the read pulse still stands would catch stale data
          if (!io_rd_r) begin
            result_r <= io.io_rdata;
            state_r <= ebc_pkg::EBC_S_IDLE;
          end
        end
      endcase
    end
  end

  assign io.io_addr = io_addr_r;
  assign io.io_wr = io_wr_r;
  assign io.io_rd = io_rd_r;
  assign io.io_wdata = io_wdata_r;
  // Interrupts held off for the whole sequence so the arm window cannot lapse
  assign io.global_irq_en = gie_r && (state_r == ebc_pkg::EBC_S_IDLE);
  assign io.flash_selfprog_active = flash_r;
  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
endmodule // ebc_host

// file: core/ebc_if.sv
// Purpose: I/O register link between the core side and the byte access device
// Assumes: One clock, pclk, drives both ends
// Notes: Accesses are single-cycle pulses; read data follows one cycle later
interface ebc_if;
  logic [5:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic cpu_stall;
  logic ready_irq;
  logic global_irq_en;
  logic flash_selfprog_active;

  modport dev (
    input io_addr, io_wr, io_rd, io_wdata, global_irq_en, flash_selfprog_active,
    output io_rdata, cpu_stall, ready_irq
  );
  modport core (
    output io_addr, io_wr, io_rd, io_wdata, global_irq_en, flash_selfprog_active,
    input io_rdata, cpu_stall, ready_irq
  );
endinterface

// file: core/ebc_pkg.sv
// Purpose: Types shared by both ends of the byte access block
// Assumes: Constants live in ebc_cfg.svh
// Notes: Nothing here is imported; use ebc_pkg::name
package ebc_pkg;
  typedef enum logic [1:0] {
    EBC_MODE_ATOMIC = 2'h0,
    EBC_MODE_ERASE = 2'h1,
    EBC_MODE_WRITE = 2'h2,
    EBC_MODE_RSVD = 2'h3
  } ebc_mode_e;

  typedef enum logic [1:0] {
    EBC_OP_RAW_WR = 2'h0,
    EBC_OP_RAW_RD = 2'h1,
    EBC_OP_BYTE_WR = 2'h2,
    EBC_OP_BYTE_RD = 2'h3
  } ebc_op_e;

  // Gray coded along the byte write path from IDLE to WAITS
  typedef enum logic [3:0] {
    EBC_S_IDLE = 4'h0,
    EBC_S_POLL = 4'h1,
    EBC_S_POLLCHK = 4'h3,
    EBC_S_PTRH = 4'h2,
    EBC_S_PTRL = 4'h6,
    EBC_S_DATA = 4'h7,
    EBC_S_ARM = 4'h5,
    EBC_S_STRIKE = 4'h4,
    EBC_S_SETTLE = 4'hC,
    EBC_S_WAITS = 4'hD,
    EBC_S_RDGET = 4'hF,
    EBC_S_RSTRB = 4'hE
  } ebc_state_e;
endpackage

// file: verif/ebc_link_monitor.sv
// Purpose: Concurrent checks on the I/O link between core side and device
// Assumes: One clock domain; presetn disables every property
// Notes: The arm window age is rebuilt here from control writes
`include "ebc_cfg.svh"
module ebc_link_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic cpu_stall,
  input wire logic ready_irq,
  input wire logic global_irq_en,
  input wire logic flash_selfprog_active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] arm_age_r;
  logic ctl_wr;
  logic strike;

  // Decode of control writes that could start programming
  assign ctl_wr = io_wr && (io_addr == `EBC_IO_CTRL);
  assign strike = ctl_wr && io_wdata[1] && !io_wdata[0];

  // Arm age: strikes count at ages 1..4, the four-cycle window; dies at 4 or on a strike
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_age_r <= 3'h0;
    end else if (ctl_wr && io_wdata[2] && !io_wdata[1]) begin
      arm_age_r <= 3'h1;
    end else if ((ctl_wr && io_wdata[1]) || (arm_age_r == 3'h4)) begin
      arm_age_r <= 3'h0;
    end else if (arm_age_r != 3'h0) begin
      arm_age_r <= arm_age_r + 3'h1;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_stall_len: assert property ($rose(cpu_stall) |->
    (cpu_stall[*2] ##1 !cpu_stall) or (cpu_stall[*4] ##1 !cpu_stall))
    else $error("stall length is neither two nor four cycles");
  chk_stall_cause: assert property ($rose(cpu_stall) |-> $past(ctl_wr))
    else $error("stall without a control write");
  chk_stall_quiet: assert property (cpu_stall |-> !io_wr && !io_rd)
    else $error("access issued during stall");
  chk_strike_unarmed: assert property (strike && arm_age_r == 3'h0 |=> !cpu_stall)
    else $error("unarmed strike stalled the core");
  chk_strike_flash: assert property (strike && flash_selfprog_active |=> !cpu_stall)
    else $error("strike accepted during flash programming");
  chk_irq_masked: assert property (flash_selfprog_active || !global_irq_en |-> !ready_irq)
    else $error("ready interrupt while masked");
  chk_irq_busy: assert property ($rose(cpu_stall) ##1 cpu_stall ##1 !cpu_stall |-> !ready_irq)
    else $error("ready interrupt during a write");
  chk_ctrl_read: assert property (io_rd && io_addr == `EBC_IO_CTRL |=>
    io_rdata[7:6] == 2'h0 && !io_rdata[0])
    else $error("control read shows top bits or read strobe");
  chk_ptrhi_read: assert property (io_rd && io_addr == `EBC_IO_PTR_HI |=>
    io_rdata[7:1] == 7'h00)
    else $error("pointer high read shows unused bits");
endmodule // ebc_link_monitor

// file: verif/eeprom_byte_access_controller_bench.sv
// Purpose: Self-checking bench for host and device joined by the I/O link
// Assumes: Short RC counts, so atomic takes 16 cycles and half modes 8
// Notes: Reset mid-write only pulses presetn; por_n stays released
`include "ebc_cfg.svh"
module eeprom_byte_access_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, prog_busy, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int n_fail, checks, cyc;

  ebc_if io_l();
  ebc_device #(.RC_DIV(2), .RC_ATOMIC(8), .RC_HALF(4)) i_ebc_device (.pclk(pclk),
    .presetn(presetn), .por_n(por_n), .io(io_l), .prog_busy(prog_busy));
  ebc_host i_ebc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .io(io_l));
  ebc_link_monitor i_ebc_link_monitor (.pclk(pclk), .presetn(presetn),
    .io_addr(io_l.io_addr), .io_wr(io_l.io_wr), .io_rd(io_l.io_rd),
    .io_wdata(io_l.io_wdata), .io_rdata(io_l.io_rdata), .cpu_stall(io_l.cpu_stall),
    .ready_irq(io_l.ready_irq), .global_irq_en(io_l.global_irq_en),
    .flash_selfprog_active(io_l.flash_selfprog_active));

  // Clock of 8 ns
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Hang guard: the whole run needs under a thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  // One APB transfer; the request holds until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Poll status until the sequencer is idle; rd keeps the last status
  task automatic idle();
    for (int i = 0; i < 100; i++) begin
      apb(1'b0, `EBC_A_STATUS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (rd[0] !== 1'b0) begin
      n_fail++;
      $display("CHECK FAILED %0t sequencer never went idle", $time);
      wrap_up();
    end
  endtask

  task automatic cmd(input logic [31:0] v);
    apb(1'b1, `EBC_A_CMD, v);
    idle();
  endtask

  function automatic logic [31:0] rawc(logic [1:0] op, logic [5:0] a, logic [7:0] d);
    return {8'h00, d, 2'h0, a, 6'h00, op};
  endfunction

  task automatic wpb(input logic v);
    for (int i = 0; i < 200 && prog_busy !== v; i++) @(posedge pclk);
    if (prog_busy !== v) begin
      n_fail++;
      $display("CHECK FAILED %0t programming flag stuck", $time);
      wrap_up();
    end
  endtask

  task automatic start(input logic [8:0] p, input logic [7:0] d, input logic [1:0] m);
    apb(1'b1, `EBC_A_ADDR, {23'h0, p});
    apb(1'b1, `EBC_A_WDATA, {24'h0, d});
    apb(1'b1, `EBC_A_CMD, {28'h0, m, 2'h2});
  endtask

  // Byte write that also measures how long programming stands
  task automatic bwr(input logic [8:0] p, input logic [7:0] d, input logic [1:0] m, input int n);
    int k;
    k = 0;
    start(p, d, m);
    for (int i = 0; i < 60 && prog_busy !== 1'b1; i++) @(posedge pclk);
    while (prog_busy === 1'b1 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    check(8'(k), 8'(n), "programming length");
    idle();
  endtask

  task automatic brd(input logic [8:0] p, input logic [7:0] e);
    apb(1'b1, `EBC_A_ADDR, {23'h0, p});
    cmd(32'h3);
    check(rd[15:8], e, "byte read back");
  endtask

  task automatic s_reset();
    cmd(rawc(2'h1, `EBC_IO_CTRL, 8'h00));
    check(rd[15:8], 8'h00, "control after reset");
    cmd(rawc(2'h0, `EBC_IO_PTR_HI, 8'hFF));
    cmd(rawc(2'h1, `EBC_IO_PTR_HI, 8'h00));
    check(rd[15:8], 8'h01, "pointer high read");
    apb(1'b0, 8'h14, 32'h0);
    check({7'h0, err}, 8'h01, "unmapped error");
    check(rd[7:0], 8'h00, "unmapped data");
  endtask

  task automatic s_modes();
    bwr(9'h1FF, 8'hA5, 2'h0, 16);
    brd(9'h1FF, 8'hA5);
    bwr(9'h1FF, 8'h00, 2'h1, 8);
    brd(9'h1FF, 8'hFF);
    bwr(9'h1FF, 8'h3C, 2'h2, 8);
    brd(9'h1FF, 8'h3C);
    bwr(9'h1FF, 8'hC3, 2'h2, 8);
    brd(9'h1FF, 8'h00);
    bwr(9'h1FF, 8'h5A, 2'h3, 0);
    brd(9'h1FF, 8'h00);
    bwr(9'h000, 8'h96, 2'h0, 16);
    brd(9'h000, 8'h96);
    brd(9'h1FF, 8'h00);
    cmd(rawc(2'h1, `EBC_IO_CTRL, 8'h00));
    check(rd[15:8] & 8'h01, 8'h00, "read strobe clears");
  endtask

  // Mode, pointer and read requests thrown at a busy write
  task automatic s_busy();
    start(9'h011, 8'h77, 2'h0);
    wpb(1'b1);
    apb(1'b1, `EBC_A_CMD, rawc(2'h0, `EBC_IO_CTRL, 8'h30));
    apb(1'b1, `EBC_A_CMD, rawc(2'h0, `EBC_IO_PTR_LO, 8'h44));
    apb(1'b1, `EBC_A_CMD, rawc(2'h0, `EBC_IO_CTRL, 8'h01));
    wpb(1'b0);
    idle();
    cmd(rawc(2'h1, `EBC_IO_CTRL, 8'h00));
    check(rd[15:8] & 8'h31, 8'h00, "mode held while busy");
    cmd(rawc(2'h1, `EBC_IO_PTR_LO, 8'h00));
    check(rd[15:8], 8'h11, "pointer held while busy");
    brd(9'h011, 8'h77);
  endtask

  task automatic s_irq();
    apb(1'b1, `EBC_A_CFG, 32'h1);
    cmd(rawc(2'h0, `EBC_IO_CTRL, 8'h08));
    check(rd[7:0] & 8'h02, 8'h02, "ready interrupt");
    cmd(rawc(2'h0, `EBC_IO_CTRL, 8'h0C));
    cmd(rawc(2'h0, `EBC_IO_CTRL, 8'h0A)); // Strike long after the arm expired
    repeat (8) @(posedge pclk);
    check({7'h0, prog_busy}, 8'h00, "late strike");
    // Back-to-back arm and strike land inside the window, so only the flash flag refuses it
    apb(1'b1, `EBC_A_CFG, 32'h3);
    apb(1'b1, `EBC_A_CMD, rawc(2'h0, `EBC_IO_CTRL, 8'h0C));
    apb(1'b1, `EBC_A_CMD, rawc(2'h0, `EBC_IO_CTRL, 8'h0A));
    idle();
    repeat (8) @(posedge pclk);
    check({7'h0, prog_busy}, 8'h00, "strike in flash programming");
    check(rd[7:0] & 8'h02, 8'h00, "interrupt masked by flash");
    apb(1'b1, `EBC_A_CFG, 32'h0);
    apb(1'b0, `EBC_A_STATUS, 32'h0);
    check(rd[7:0] & 8'h02, 8'h00, "interrupt masked globally");
    // Same pair without the flash flag must start programming
    apb(1'b1, `EBC_A_CMD, rawc(2'h0, `EBC_IO_CTRL, 8'h0C));
    apb(1'b1, `EBC_A_CMD, rawc(2'h0, `EBC_IO_CTRL, 8'h0A));
    wpb(1'b1);
    check({7'h0, prog_busy}, 8'h01, "armed strike starts");
    wpb(1'b0);
    idle();
  endtask

  task automatic pulse_rst();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic s_rst();
    start(9'h0AB, 8'h00, 2'h1);
    wpb(1'b1);
    pulse_rst();
    @(posedge pclk);
    check({7'h0, prog_busy}, 8'h01, "write survives reset");
    wpb(1'b0);
    cmd(rawc(2'h1, `EBC_IO_CTRL, 8'h00));
    check(rd[15:8] & 8'h30, 8'h10, "mode kept while busy");
    brd(9'h0AB, 8'hFF);
    pulse_rst();
    cmd(rawc(2'h1, `EBC_IO_CTRL, 8'h00));
    check(rd[15:8] & 8'h30, 8'h00, "mode cleared by reset");
  endtask

  initial begin
    presetn = 1'b0;
    por_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_fail = 0;
    checks = 0;
    cyc = 0;
    repeat (12) @(posedge pclk);
    por_n <= 1'b1;
    presetn <= 1'b1;
    s_reset();
    s_modes();
    s_busy();
    s_irq();
    s_rst();
    wrap_up();
  end
endmodule // eeprom_byte_access_controller_bench
